// >>> rtl/serial_regs_pkg.sv
package serial_regs_pkg;
	// Command byte layout
	localparam int CMD_RW_BIT = 6;
	localparam int CMD_MSB = 7;
	localparam logic [5:0] ADDR_COMMAND = 6'h00;
	localparam logic [5:0] ADDR_PIN = 6'h01;
	localparam logic [5:0] ADDR_REVISION = 6'h02;
	localparam logic [5:0] ADDR_TEST = 6'h03;
	localparam logic [5:0] ADDR_MODE_BASE = 6'h38;
	// Pin register fields
	localparam int PIN_COMMON_LEVEL = 7;
	localparam int PIN_AUX_LEVEL = 6;
	localparam int PIN_COMMON_DIR = 5;
	localparam int PIN_AUX_DIR = 4;
	localparam int PIN_READY_POLICY = 3;
	localparam int PIN_SYNC_EN = 0;
	localparam logic [7:0] PIN_RESET = 8'h30;
	localparam logic [7:0] PIN_WRITE_MASK = 8'hF9;
	// Revision: upper nibble arbitrary, lower nibble family code (arbitrary)
	localparam logic [3:0] REV_CODE = 4'h0;
	localparam logic [3:0] FAMILY_CODE = 4'h5;
	localparam logic [23:0] TEST_RESET = 24'h000000;
	localparam logic [7:0] MODE_RESET = 8'h00;
	// Serial sizes
	localparam int RESYNC_ONES = 32;
	localparam logic [5:0] RESYNC_LAST = 6'h1F;
	localparam logic [4:0] BITS_8 = 5'h07;
	localparam logic [4:0] BITS_24 = 5'h17;

	typedef enum logic [1:0] {ST_CMD, ST_WRITE, ST_READ} link_state_t;

	// Completed transfer handed from link domain to core domain
	typedef struct packed {
		logic [5:0] addr;
		logic [23:0] data;
	} write_word_t;
endpackage

// >>> rtl/adc_serial_register_access.sv
`timescale 1ns/1ps
// What this block does
// [R1] Command register is 8-bit write-only at address zero, never read back.
// [R2] Host opens every transaction with a command byte.
// [R3] Command byte sets direction and target of the single following transfer.
// [R4] After reset or a finished transfer, interface expects a command byte.
// [R5] 32 or more ones with select low fully resets interface and registers.
// [R6] Host keeps data input low during long reads to avoid reset.
// [R7] Host writes zero in command bit 7.
// [R8] Command bit 6: zero writes target, one reads it back.
// [R9] Command bits 5..0 pick register; low three pick channel.
// [R10] Mode write: low address bits pick the channel the mode runs on.
// [R11] Channel maps to single input n or pair 2(n mod 4) by pairing bits.
// [R12] Common pin as digital output is driven from pin bit 7.
// [R13] Aux pin driven from bit 6 as output; bit 6 reads live level as input.
// [R14] Pin bit 5 one: common pin analog; zero: digital output.
// [R15] Pin bit 4 one: aux pin input; zero: output.
// [R16] Ready low on any unread channel, or all enabled when bit 3 set.
// [R17] Host writes zero to pin bits 2 and 1.
// [R18] Pin bit 0 turns the aux pin into the sync function.
// [R19] Pin register resets to 30h plus 40h when aux pin is high; the code also adds 80h when common pin is high.
// [R20] Revision reads factory code high nibble, family code low nibble.
// [R21] Host leaves the 24-bit test register unchanged.
// [R22] One mode register, written at eight addresses, read only at the first.
// [R23] Bytes move MSB first, sampled on serial clock while select is low.
module adc_serial_register_access (
	// Core clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// Serial link, clocked by the host
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic DIN,
	output logic DOUT,
	// General pins
	input wire logic COMMON_PIN_IN,
	output logic COMMON_PIN_OUT,
	output logic COMMON_PIN_OE,
	input wire logic AUX_PIN_IN,
	output logic AUX_PIN_OUT,
	output logic AUX_PIN_OE,
	output logic SYNC_ENABLE,
	// Conversion engine side
	input wire logic [7:0] CHANNEL_UNREAD,
	input wire logic [7:0] CHANNEL_ENABLED,
	input wire logic [7:0] PAIRING_DIFF,
	output logic READY_N,
	output logic [7:0] MODE_VALUE,
	output logic [2:0] MODE_CHANNEL,
	output logic [2:0] MODE_INPUT,
	output logic MODE_PULSE,
	output logic FULL_RESET
);
	// ---------------- Link domain (SCLK) ----------------
	serial_regs_pkg::link_state_t state;
	logic [23:0] shift_in;
	logic [4:0] bit_cnt;
	logic [4:0] bit_last;
	logic [5:0] target;
	logic [5:0] ones_cnt;
	logic resync;
	logic [23:0] shift_out;
	logic wr_toggle;
	serial_regs_pkg::write_word_t wr_word;
	logic rs_toggle;
	logic [23:0] rd_snap;
	logic read_loaded;

	wire [23:0] next_shift = {shift_in[22:0], DIN};
	wire cmd_done = (state == serial_regs_pkg::ST_CMD) && (bit_cnt == serial_regs_pkg::BITS_8);
	wire data_done = (state != serial_regs_pkg::ST_CMD) && (bit_cnt == bit_last);
	wire ones_full = DIN && (ones_cnt == serial_regs_pkg::RESYNC_LAST);

	// Run-of-ones detector; counter saturates so a long run fires once
	always_ff @(posedge SCLK) begin
		if (CS_N || !DIN) begin
			ones_cnt <= 6'h00;
		end else if (ones_cnt != 6'h3F) begin
			ones_cnt <= ones_cnt + 6'h01; // [R5]
		end
	end

	// Byte assembly, MSB first, on rising SCLK with select low
	always_ff @(posedge SCLK) begin
		if (CS_N || ones_full) begin
			bit_cnt <= 5'h00;
			state <= serial_regs_pkg::ST_CMD; // [R4] [R5]
		end else if (cmd_done) begin
			bit_cnt <= 5'h00;
			target <= next_shift[5:0]; // [R9]
			bit_last <= (next_shift[5:0] == serial_regs_pkg::ADDR_TEST) ?
				serial_regs_pkg::BITS_24 : serial_regs_pkg::BITS_8;
			state <= next_shift[serial_regs_pkg::CMD_RW_BIT] ?
				serial_regs_pkg::ST_READ : serial_regs_pkg::ST_WRITE; // [R3] [R8]
		end else if (data_done) begin
			bit_cnt <= 5'h00;
			state <= serial_regs_pkg::ST_CMD; // [R4]
		end else begin
			bit_cnt <= bit_cnt + 5'h01;
		end
		shift_in <= next_shift; // [R23]
	end
	// A partial byte held across CS_N high is abandoned only at a rising SCLK edge seen while CS_N is high.

	// Write hand-off: word held stable until the core sees the toggle
	always_ff @(posedge SCLK) begin
		if (SRST) begin
			wr_toggle <= 1'b0;
		end else if (!CS_N && data_done && state == serial_regs_pkg::ST_WRITE) begin
			wr_word.addr <= target;
			wr_word.data <= next_shift;
			wr_toggle <= ~wr_toggle;
		end
	end
	// Resync event as a toggle so the core catches even a short pulse
	always_ff @(posedge SCLK) begin
		if (SRST) begin
			rs_toggle <= 1'b0;
		end else if (!CS_N && ones_full && ones_cnt != 6'h3F) begin
			rs_toggle <= ~rs_toggle; // [R5]
		end
	end

	// Read output path sits after the core read mux, which it samples

	// ---------------- Core domain (CLK) ----------------
	logic [2:0] wr_sync;
	logic [2:0] rs_sync;
	logic [2:0] aux_sync;
	logic [2:0] com_sync;
	logic wr_seen;
	logic rs_seen;
	logic [7:0] pin_ctrl;
	logic [23:0] test_reg;
	logic [7:0] mode_reg;
	logic [2:0] mode_chan;
	logic mode_pulse;
	logic reset_pulse;
	logic aux_level;
	logic com_level;

	// Three-stage synchronisers; stages 1 and 2 agreeing counts as a change
	always_ff @(posedge CLK) begin
		wr_sync <= {wr_sync[1:0], wr_toggle};
		rs_sync <= {rs_sync[1:0], rs_toggle};
		aux_sync <= {aux_sync[1:0], AUX_PIN_IN};
		com_sync <= {com_sync[1:0], COMMON_PIN_IN};
	end
	wire wr_event = (wr_sync[1] == wr_sync[2]) && (wr_sync[2] != wr_seen);
	wire rs_event = (rs_sync[1] == rs_sync[2]) && (rs_sync[2] != rs_seen);
	always_ff @(posedge CLK) begin
		if (aux_sync[1] == aux_sync[2]) begin
			aux_level <= aux_sync[2];
		end
		if (com_sync[1] == com_sync[2]) begin
			com_level <= com_sync[2];
		end
	end

	// Address decode for completed writes
	wire [5:0] w_addr = wr_word.addr;
	wire hit_pin = wr_event && w_addr == serial_regs_pkg::ADDR_PIN;
	wire hit_test = wr_event && w_addr == serial_regs_pkg::ADDR_TEST;
	wire hit_mode = wr_event && w_addr[5:3] == serial_regs_pkg::ADDR_MODE_BASE[5:3]; // [R22]
	wire do_reset = SRST || rs_event;

	// Register file; pin reset also catches the aux pin level once clocked
	always_ff @(posedge CLK) begin
		if (do_reset) begin
			pin_ctrl <= serial_regs_pkg::PIN_RESET; // [R19]
			test_reg <= serial_regs_pkg::TEST_RESET;
			mode_reg <= serial_regs_pkg::MODE_RESET;
			mode_chan <= 3'h0;
			mode_pulse <= 1'b0;
		end else begin
			// Reserved pin bits are forced low whatever the host sends
			if (hit_pin) begin
				pin_ctrl <= wr_word.data[7:0] & serial_regs_pkg::PIN_WRITE_MASK;
			end
			if (hit_test) begin
				test_reg <= wr_word.data;
			end
			if (hit_mode) begin
				mode_reg <= wr_word.data[7:0];
				mode_chan <= w_addr[2:0]; // [R10]
			end
			mode_pulse <= hit_mode;
		end
	end
	always_ff @(posedge CLK) begin
		if (SRST) begin
			wr_seen <= 1'b0;
			rs_seen <= 1'b0;
			reset_pulse <= 1'b0;
		end else begin
			if (wr_event) begin
				wr_seen <= wr_sync[2];
			end
			if (rs_event) begin
				rs_seen <= rs_sync[2];
			end
			reset_pulse <= rs_event; // [R5]
		end
	end

	// Pin register read: level bits show live pins where set as input or analog
	wire aux_is_in = pin_ctrl[serial_regs_pkg::PIN_AUX_DIR];
	wire com_is_analog = pin_ctrl[serial_regs_pkg::PIN_COMMON_DIR];
	wire aux_read = aux_is_in ? aux_level : pin_ctrl[serial_regs_pkg::PIN_AUX_LEVEL]; // [R13]
	wire com_read = com_is_analog ? com_level : pin_ctrl[serial_regs_pkg::PIN_COMMON_LEVEL];
	wire [7:0] pin_read = {com_read, aux_read, pin_ctrl[5:0]}; // [R19]

	// Read address taken from the byte still being shifted in, so the
	// answer is ready on the very edge that completes the command byte
	wire [5:0] rd_addr = next_shift[5:0];

	// Read mux; command and write-only mode aliases read as zero
	logic [23:0] next_rd;
	always_comb begin
		next_rd = 24'h000000; // [R1]
		case (rd_addr)
			serial_regs_pkg::ADDR_PIN: next_rd = {16'h0000, pin_read};
			serial_regs_pkg::ADDR_REVISION: next_rd = {16'h0000, serial_regs_pkg::REV_CODE,
				serial_regs_pkg::FAMILY_CODE}; // [R20]
			serial_regs_pkg::ADDR_TEST: next_rd = test_reg;
			serial_regs_pkg::ADDR_MODE_BASE: next_rd = {16'h0000, mode_reg}; // [R22]
			default: next_rd = 24'h000000;
		endcase
	end

	// Pin drivers
	assign COMMON_PIN_OE = !com_is_analog; // [R14]
	assign COMMON_PIN_OUT = pin_ctrl[serial_regs_pkg::PIN_COMMON_LEVEL]; // [R12]
	assign AUX_PIN_OE = !aux_is_in && !pin_ctrl[serial_regs_pkg::PIN_SYNC_EN]; // [R15] [R18]
	assign AUX_PIN_OUT = pin_ctrl[serial_regs_pkg::PIN_AUX_LEVEL]; // [R13]
	assign SYNC_ENABLE = pin_ctrl[serial_regs_pkg::PIN_SYNC_EN]; // [R18]

	// Ready policy: any unread, or all enabled unread
	wire any_unread = |CHANNEL_UNREAD;
	wire all_unread = (CHANNEL_ENABLED != 8'h00) &&
		((CHANNEL_UNREAD & CHANNEL_ENABLED) == CHANNEL_ENABLED);
	assign READY_N = pin_ctrl[serial_regs_pkg::PIN_READY_POLICY] ? !all_unread : !any_unread; // [R16]

	// Input mapping for the channel the mode acts on
	wire diff = PAIRING_DIFF[mode_chan];
	assign MODE_INPUT = diff ? {mode_chan[1:0], 1'b0} : mode_chan; // [R11]
	assign MODE_VALUE = mode_reg;
	assign MODE_CHANNEL = mode_chan;
	assign MODE_PULSE = mode_pulse;
	assign FULL_RESET = reset_pulse;

	// ---------------- Read path (SCLK) ----------------
	// Core registers move only on writes, resets, resyncs and pin changes, and the
	// host cannot write while it reads, so sampling them here is safe.
	// A live pin level toggling in the same instant is the one exception.
	wire rd_wide = (rd_addr == serial_regs_pkg::ADDR_TEST);
	wire [23:0] rd_aligned = rd_wide ? next_rd : {next_rd[7:0], 16'h0000};
	wire rd_capture = !CS_N && cmd_done;

	// Snapshot of the addressed register, taken with the command byte
	always_ff @(posedge SCLK) begin
		if (rd_capture) begin
			rd_snap <= rd_aligned; // [R3]
		end
	end

	// Load flag: the first falling edge of a read presents the MSB
	always_ff @(negedge SCLK) begin
		if (CS_N || state != serial_regs_pkg::ST_READ) begin
			read_loaded <= 1'b0;
		end else begin
			read_loaded <= 1'b1;
		end
	end

	// Output shifter; falling edges give the host a full half period
	always_ff @(negedge SCLK) begin
		if (CS_N || state != serial_regs_pkg::ST_READ) begin
			shift_out <= 24'h000000;
		end else if (!read_loaded) begin
			shift_out <= rd_snap; // [R23]
		end else begin
			shift_out <= {shift_out[22:0], 1'b0}; // [R23]
		end
	end

	// Output holds the last bit read until the next falling edge, then stays low outside reads
	assign DOUT = shift_out[23];
endmodule // adc_serial_register_access

// >>> test/adc_serial_register_access_chk.sv
`timescale 1ns/1ps
// Port relations of the register front end
module adc_serial_register_access_chk (
	// Core clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// Watched ports
	input wire logic AUX_PIN_OE,
	input wire logic COMMON_PIN_OE,
	input wire logic SYNC_ENABLE,
	input wire logic [7:0] CHANNEL_UNREAD,
	input wire logic [7:0] CHANNEL_ENABLED,
	input wire logic [7:0] PAIRING_DIFF,
	input wire logic READY_N,
	input wire logic [7:0] MODE_VALUE,
	input wire logic [2:0] MODE_CHANNEL,
	input wire logic [2:0] MODE_INPUT,
	input wire logic MODE_PULSE,
	input wire logic FULL_RESET
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	// Reset picture: pins released, mode idle
	sequence s_cleared;
		!COMMON_PIN_OE && !AUX_PIN_OE && !SYNC_ENABLE && MODE_VALUE == 8'h00;
	endsequence
	sequence s_after_resync; ##[0:1] s_cleared; endsequence
	property p_ready_none; CHANNEL_UNREAD == 8'h00 |-> READY_N; endproperty
	a_ready_none: assert property (p_ready_none) else $error("ready low with no data");
	property p_ready_all;
		CHANNEL_UNREAD == 8'hFF && CHANNEL_ENABLED != 8'h00 |-> !READY_N;
	endproperty
	a_ready_all: assert property (p_ready_all) else $error("ready high with all data");
	property p_sync; SYNC_ENABLE |-> !AUX_PIN_OE; endproperty
	a_sync: assert property (p_sync) else $error("aux driven while sync on");
	property p_input;
		MODE_PULSE |-> MODE_INPUT == (PAIRING_DIFF[MODE_CHANNEL] ?
			{MODE_CHANNEL[1:0], 1'b0} : MODE_CHANNEL);
	endproperty
	a_input: assert property (p_input) else $error("mode input mapping wrong");
	property p_pulse; MODE_PULSE |=> !MODE_PULSE; endproperty
	a_pulse: assert property (p_pulse) else $error("mode pulse too long");
	property p_resync; FULL_RESET |-> s_after_resync; endproperty
	a_resync: assert property (p_resync) else $error("resync left registers");
	property p_once; FULL_RESET |=> !FULL_RESET; endproperty
	a_once: assert property (p_once) else $error("resync pulse too long");
	property p_srst; $fell(SRST) |-> s_cleared; endproperty
	a_srst: assert property (p_srst) else $error("reset values wrong");
	property p_mode;
		$changed(MODE_VALUE) && !$past(SRST) && !FULL_RESET && !$past(FULL_RESET)
			|-> (MODE_PULSE || $past(MODE_PULSE)) or (##1 MODE_PULSE);
	endproperty
	a_mode: assert property (p_mode) else $error("mode changed without write");
endmodule // adc_serial_register_access_chk

// >>> test/serial_host_model.sv
`timescale 1ns/1ps
// Host on the serial link; its clock stands high between frames
module serial_host_model (
	// Serial pins
	output logic SCLK,
	output logic CS_N,
	output logic DIN,
	input wire logic DOUT,
	// Read results
	output logic [23:0] rd_data,
	output logic rd_tog
);
	initial begin
		SCLK = 1'b1;
		CS_N = 1'b1;
		DIN = 1'b0;
		rd_tog = 1'b0;
	end
	// Change on fall, device samples on rise
	task automatic bit_io(input logic b, output logic q);
		SCLK = 1'b0;
		DIN = b;
		#3;
		SCLK = 1'b1;
		q = DOUT;
		#3;
	endtask
	// Command byte then one data unit, MSB first
	task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int nb);
		logic q;
		rd_data = 24'h000000;
		CS_N = 1'b0;
		#3;
		for (int i = 7; i >= 0; i--) bit_io(cmd[i], q);
		for (int i = nb - 1; i >= 0; i--) begin
			bit_io(cmd[6] ? 1'b0 : wd[i], q);
			rd_data[i] = q;
		end
		CS_N = 1'b1;
		DIN = ~DIN;
		if (cmd[6]) rd_tog = ~rd_tog;
	endtask
	// Long run of ones for resync
	task automatic ones(input int n);
		logic q;
		CS_N = 1'b0;
		#3;
		repeat (n) bit_io(1'b1, q);
		CS_N = 1'b1;
		DIN = 1'b0;
	endtask
	// Idle clocks with select high, only while the device is in reset
	task automatic idle(input int n);
		repeat (n) begin
			SCLK = 1'b0;
			#3;
			SCLK = 1'b1;
			#3;
		end
	endtask
endmodule // serial_host_model

// >>> test/adc_serial_register_access_tb.sv
`timescale 1ns/1ps
module adc_serial_register_access_tb;
	logic clk, srst, sclk, cs_n, din, dout, com_drv, com_out, com_oe, aux_drv, aux_out, aux_oe;
	logic sync_en, ready_n, mode_pulse, full_rst, rd_tog, seen;
	logic [7:0] unread, enabled, pairing, mode_value, v;
	logic [2:0] mode_ch, mode_in;
	logic [23:0] rd_data;
	logic [23:0] expq[$];
	logic [31:0] seed, rs;
	int miscompares, num_checks;
	wire com_in, aux_in;
	// Pin wires resolved from the enables
	assign com_in = com_oe ? com_out : com_drv;
	assign aux_in = aux_oe ? aux_out : aux_drv;
	adc_serial_register_access DUT (.CLK(clk), .SRST(srst), .SCLK(sclk), .CS_N(cs_n), .DIN(din),
		.DOUT(dout), .COMMON_PIN_IN(com_in), .COMMON_PIN_OUT(com_out), .COMMON_PIN_OE(com_oe),
		.AUX_PIN_IN(aux_in), .AUX_PIN_OUT(aux_out), .AUX_PIN_OE(aux_oe), .SYNC_ENABLE(sync_en),
		.CHANNEL_UNREAD(unread), .CHANNEL_ENABLED(enabled), .PAIRING_DIFF(pairing),
		.READY_N(ready_n), .MODE_VALUE(mode_value), .MODE_CHANNEL(mode_ch), .MODE_INPUT(mode_in),
		.MODE_PULSE(mode_pulse), .FULL_RESET(full_rst));
	serial_host_model host (.SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout),
		.rd_data(rd_data), .rd_tog(rd_tog));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input string what, input logic [23:0] seen_v, input logic [23:0] exp_v);
		num_checks++;
		if (seen_v !== exp_v) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp_v, seen_v);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [23:0] d, input int nb);
		host.xfer({2'b00, a}, d, nb);
		repeat (10) @(posedge clk);
	endtask
	task automatic rd(input logic [5:0] a, input logic [23:0] e, input int nb);
		expq.push_back(e);
		host.xfer({2'b01, a}, 24'h000000, nb);
		repeat (2) @(posedge clk);
	endtask
	task automatic wrap_up();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Engine inputs, biased to hit none and all unread
	always @(negedge clk) begin
		seed = xs(seed);
		unread <= seed[31] ? {8{seed[0]}} : seed[15:8];
		enabled <= seed[23:16];
	end
	always @(posedge clk) if (full_rst === 1'b1) seen <= 1'b1;
	// Read results against oldest note
	initial begin
		wait (srst === 1'b0);
		forever begin
			@(rd_tog);
			chk("read", rd_data, expq.pop_front());
		end
	end
	initial begin
		#100000;
		miscompares++;
		$display("watchdog expired");
		wrap_up();
	end
	initial begin
		srst = 1'b1;
		seed = 32'h9CC7CC7F;
		rs = 32'h9CC7CC7F;
		com_drv = 1'b0;
		aux_drv = 1'b1;
		pairing = 8'h00;
		seen = 1'b0;
		// Clock the link idle so its toggles see reset too
		host.idle(4);
		repeat (8) @(posedge clk);
		@(negedge clk) srst = 1'b0;
		repeat (10) @(posedge clk);
		rd(ADDR_PIN_OF(), 24'h000070, 8);
		rd(serial_regs_pkg::ADDR_REVISION,
			{16'h0000, serial_regs_pkg::REV_CODE, serial_regs_pkg::FAMILY_CODE}, 8);
		rd(serial_regs_pkg::ADDR_COMMAND, 24'h000000, 8);
		rd(6'h39, 24'h000000, 8);
		rd(serial_regs_pkg::ADDR_TEST, serial_regs_pkg::TEST_RESET, 24);
		$display("test reset values done");
		repeat (4) begin
			rs = xs(rs);
			v = rs[7:0] & 8'hC8;
			wr(ADDR_PIN_OF(), {16'h0000, v}, 8);
			chk("common_out", com_out, v[7]);
			chk("pin_oe", {com_oe, aux_oe}, 24'h000003);
			chk("aux_out", aux_out, v[6]);
			rd(ADDR_PIN_OF(), {16'h0000, v}, 8);
		end
		wr(ADDR_PIN_OF(), 24'h000030, 8);
		@(negedge clk) {com_drv, aux_drv} = 2'b10;
		rd(ADDR_PIN_OF(), 24'h0000B0, 8);
		wr(ADDR_PIN_OF(), 24'h000001, 8);
		chk("sync", {sync_en, aux_oe, com_oe}, 24'h000005);
		$display("test pins done");
		for (int p = 0; p < 2; p++) begin
			wr(ADDR_PIN_OF(), p ? 24'h000008 : 24'h000000, 8);
			repeat (30) begin
				@(posedge clk);
				#1;
				if (enabled != 8'h00)
					chk("ready", ready_n, p ? (enabled & ~unread) != 8'h00 : unread == 8'h00);
			end
		end
		for (int c = 0; c < 8; c++) begin
			rs = xs(rs);
			@(negedge clk) pairing = rs[7:0];
			wr(serial_regs_pkg::ADDR_MODE_BASE + 6'(c), {21'h000004, c[2:0]}, 8);
			chk("mode_ch", mode_ch, c[2:0]);
		end
		rd(serial_regs_pkg::ADDR_MODE_BASE, 24'h000027, 8);
		$display("test modes done");
		host.ones(serial_regs_pkg::RESYNC_ONES);
		repeat (10) @(posedge clk);
		chk("full_reset", seen, 24'h000001);
		rd(ADDR_PIN_OF(), 24'h0000B0, 8);
		rd(serial_regs_pkg::ADDR_MODE_BASE, 24'h000000, 8);
		$display("test resync done");
		wrap_up();
	end
	function automatic logic [5:0] ADDR_PIN_OF();
		return serial_regs_pkg::ADDR_PIN;
	endfunction
endmodule // adc_serial_register_access_tb
bind adc_serial_register_access adc_serial_register_access_chk u_chk (.CLK(CLK), .SRST(SRST),
	.AUX_PIN_OE(AUX_PIN_OE), .COMMON_PIN_OE(COMMON_PIN_OE), .SYNC_ENABLE(SYNC_ENABLE),
	.CHANNEL_UNREAD(CHANNEL_UNREAD), .CHANNEL_ENABLED(CHANNEL_ENABLED),
	.PAIRING_DIFF(PAIRING_DIFF), .READY_N(READY_N), .MODE_VALUE(MODE_VALUE),
	.MODE_CHANNEL(MODE_CHANNEL), .MODE_INPUT(MODE_INPUT), .MODE_PULSE(MODE_PULSE),
	.FULL_RESET(FULL_RESET));
